/* File: verilog/gpio_pkg.sv */
package gpio_pkg;

    // pins served by this port
    localparam int NPINS = 26;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CODE_W = 3;
    localparam int FIELD_W = 4;
    localparam int SEL_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIRECTION = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SENSE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_BOTH = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_POLARITY = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_RAW = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_MASKED = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_FUNC0 = 8'h2C;
    localparam logic [ADDR_W-1:0] OFF_FUNC1 = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_FUNC2 = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_FUNC3 = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_OUT_SET = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_OUT_CLR = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE = 8'h44;

    // reset values
    localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
    localparam logic [DATA_W-1:0] RST_FUNC1 = 32'h00000110;
    localparam logic [NPINS-1:0] RST_PINS = 26'h0000000;
    localparam logic [SEL_W-1:0] RST_SEL = 5'h00;

    // pin function codes; any other code acts as general purpose
    typedef enum logic [CODE_W-1:0] {
        FN_GPIO = 3'b000,
        FN_ALT_ONE = 3'b001,
        FN_ALT_ZERO = 3'b100,
        FN_ALT_TWO = 3'b101
    } pin_func_e;

endpackage

/* File: verilog/gpio_irq_pin_function.sv */
`timescale 1ns/100ps
// Function
// - both-edge bit selects one or two edges
// - polarity picks falling/low or rising/high
// - mask bit gates pin interrupt to processor
// - raw status readable regardless of mask
// - masked status shows only enabled events
// - writing one to clear word clears status
// - function code selects gpio or serial role
// - second function word resets two pins serial
// - third and fourth function words reset zero
// - set word forces output bits high
// - clear word forces output bits low
// - capture select routes pin to timers
// - sense bit picks edge or level detection
// - raw bit sets when pin matches setting
// - raw clear also clears masked status
// - data drives pin only in gpio output
module gpio_irq_pin_function #(
    parameter int NPINS = gpio_pkg::NPINS,
    parameter int SEL_W = gpio_pkg::SEL_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
    input wire logic [gpio_pkg::DATA_W-1:0] pwdata,
    output logic [gpio_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_level,
    input wire logic [NPINS-1:0] alt_function_zero_out,
    input wire logic [NPINS-1:0] alt_function_zero_oe,
    input wire logic [NPINS-1:0] alt_function_one_out,
    input wire logic [NPINS-1:0] alt_function_one_oe,
    input wire logic [NPINS-1:0] alt_function_two_out,
    input wire logic [NPINS-1:0] alt_function_two_oe,
    output logic [NPINS-1:0] alt_function_zero_sel,
    output logic [NPINS-1:0] alt_function_one_sel,
    output logic [NPINS-1:0] alt_function_two_sel,
    output logic timer_capture,
    output logic irq
);
    localparam int DW = gpio_pkg::DATA_W;
    localparam int PAD = DW - NPINS;

    logic [NPINS-1:0] sync1_r, sync2_r, prev_r;
    logic [NPINS-1:0] data_r, dir_r, sense_r, both_r, pol_r, mask_r;
    logic [NPINS-1:0] raw_r;
    logic [DW-1:0] func0_r, func1_r, func2_r, func3_r;
    logic [SEL_W-1:0] capture_sel_r;
    logic [DW-1:0] prdata_r;
    logic pready_r, pslverr_r, irq_r, capture_r;
    logic [NPINS-1:0] pin_out_r, pin_oe_r;
    logic [NPINS-1:0] alt0_sel_r, alt1_sel_r, alt2_sel_r;

    // bus decode
    wire setup_w = psel & ~penable;
    wire access_w = psel & penable & pready_r;
    wire wr_w = access_w & pwrite;
    wire [DW-1:0] wdata_w = pwdata;
    wire [NPINS-1:0] wpins_w = pwdata[NPINS-1:0];
    wire hit_data = paddr == gpio_pkg::OFF_DATA;
    wire hit_dir = paddr == gpio_pkg::OFF_DIRECTION;
    wire hit_sense = paddr == gpio_pkg::OFF_SENSE;
    wire hit_both = paddr == gpio_pkg::OFF_BOTH;
    wire hit_pol = paddr == gpio_pkg::OFF_POLARITY;
    wire hit_mask = paddr == gpio_pkg::OFF_MASK;
    wire hit_raw = paddr == gpio_pkg::OFF_RAW;
    wire hit_masked = paddr == gpio_pkg::OFF_MASKED;
    wire hit_clear = paddr == gpio_pkg::OFF_CLEAR;
    wire hit_f0 = paddr == gpio_pkg::OFF_FUNC0;
    wire hit_f1 = paddr == gpio_pkg::OFF_FUNC1;
    wire hit_f2 = paddr == gpio_pkg::OFF_FUNC2;
    wire hit_f3 = paddr == gpio_pkg::OFF_FUNC3;
    wire hit_set = paddr == gpio_pkg::OFF_OUT_SET;
    wire hit_clr = paddr == gpio_pkg::OFF_OUT_CLR;
    wire hit_cap = paddr == gpio_pkg::OFF_CAPTURE;
    wire hit_w = hit_data | hit_dir | hit_sense | hit_both | hit_pol
        | hit_mask | hit_raw | hit_masked | hit_clear | hit_f0 | hit_f1
        | hit_f2 | hit_f3 | hit_set | hit_clr | hit_cap;

    wire [NPINS-1:0] masked_w = raw_r & mask_r;
    wire [NPINS-1:0] clr_mask_w = (wr_w & hit_clear) ? wpins_w
        : {NPINS{1'b0}};
    wire [NPINS-1:0] set_out_w = (wr_w & hit_set) ? wpins_w
        : {NPINS{1'b0}};
    wire [NPINS-1:0] clr_out_w = (wr_w & hit_clr) ? wpins_w
        : {NPINS{1'b0}};

    // reads of data return the pin levels; write-only words read zero
    wire [DW-1:0] rd_w =
        hit_data ? {{PAD{1'b0}}, sync2_r} :
        hit_dir ? {{PAD{1'b0}}, dir_r} :
        hit_sense ? {{PAD{1'b0}}, sense_r} :
        hit_both ? {{PAD{1'b0}}, both_r} :
        hit_pol ? {{PAD{1'b0}}, pol_r} :
        hit_mask ? {{PAD{1'b0}}, mask_r} :
        hit_raw ? {{PAD{1'b0}}, raw_r} :
        hit_masked ? {{PAD{1'b0}}, masked_w} :
        hit_f0 ? func0_r :
        hit_f1 ? func1_r :
        hit_f2 ? func2_r :
        hit_f3 ? func3_r :
        hit_cap ? {{(DW-SEL_W){1'b0}}, capture_sel_r} :
        gpio_pkg::RST_ZERO;

    // per-pin event detection and function mux
    wire [4*DW-1:0] func_flat_w = {func3_r, func2_r, func1_r, func0_r};
    logic [NPINS-1:0] evt_w, gpio_w, alt0_w, alt1_w, alt2_w;
    logic [NPINS-1:0] out_w, oe_w;

    genvar p;
    generate
        for (p = 0; p < NPINS; p = p + 1) begin : g_pin
            wire rise = sync2_r[p] & ~prev_r[p];
            wire fall = ~sync2_r[p] & prev_r[p];
            wire lvl = pol_r[p] ? sync2_r[p] : ~sync2_r[p];
            wire one_edge = pol_r[p] ? rise : fall;
            wire edge_hit = both_r[p] ? (rise | fall) : one_edge;
            wire [gpio_pkg::CODE_W-1:0] code =
                func_flat_w[gpio_pkg::FIELD_W*p +: gpio_pkg::CODE_W];
            assign evt_w[p] = sense_r[p] ? lvl : edge_hit;
            assign alt0_w[p] = code == gpio_pkg::FN_ALT_ZERO;
            assign alt1_w[p] = code == gpio_pkg::FN_ALT_ONE;
            assign alt2_w[p] = code == gpio_pkg::FN_ALT_TWO;
            assign gpio_w[p] = ~(alt0_w[p] | alt1_w[p] | alt2_w[p]);
            assign out_w[p] = alt0_w[p] ? alt_function_zero_out[p] :
                alt1_w[p] ? alt_function_one_out[p] :
                alt2_w[p] ? alt_function_two_out[p] : data_r[p];
            assign oe_w[p] = alt0_w[p] ? alt_function_zero_oe[p] :
                alt1_w[p] ? alt_function_one_oe[p] :
                alt2_w[p] ? alt_function_two_oe[p] : dir_r[p];
        end
    endgenerate

    // set wins over a clear in the same cycle
    wire [NPINS-1:0] raw_nxt = (raw_r & ~clr_mask_w) | evt_w;
    wire [NPINS-1:0] data_nxt = (wr_w & hit_data) ? wpins_w
        : ((data_r | set_out_w) & ~clr_out_w);
    wire sel_ok_w = capture_sel_r < SEL_W'(NPINS);
    wire capture_nxt = sel_ok_w ? sync2_r[capture_sel_r] : 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= gpio_pkg::RST_PINS;
            sync2_r <= gpio_pkg::RST_PINS;
            prev_r <= gpio_pkg::RST_PINS;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= gpio_pkg::RST_PINS;
            dir_r <= gpio_pkg::RST_PINS;
            sense_r <= gpio_pkg::RST_PINS;
            both_r <= gpio_pkg::RST_PINS;
            pol_r <= gpio_pkg::RST_PINS;
            mask_r <= gpio_pkg::RST_PINS;
            raw_r <= gpio_pkg::RST_PINS;
        end else begin
            data_r <= data_nxt;
            raw_r <= raw_nxt;
            if (wr_w && hit_dir) dir_r <= wpins_w;
            if (wr_w && hit_sense) sense_r <= wpins_w;
            if (wr_w && hit_both) both_r <= wpins_w;
            if (wr_w && hit_pol) pol_r <= wpins_w;
            if (wr_w && hit_mask) mask_r <= wpins_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func0_r <= gpio_pkg::RST_ZERO;
            func1_r <= gpio_pkg::RST_FUNC1;
            func2_r <= gpio_pkg::RST_ZERO;
            func3_r <= gpio_pkg::RST_ZERO;
            capture_sel_r <= gpio_pkg::RST_SEL;
        end else begin
            if (wr_w && hit_f0) func0_r <= wdata_w;
            if (wr_w && hit_f1) func1_r <= wdata_w;
            if (wr_w && hit_f2) func2_r <= wdata_w;
            if (wr_w && hit_f3) func3_r <= wdata_w;
            if (wr_w && hit_cap) capture_sel_r <= wdata_w[SEL_W-1:0];
        end
    end

    // one wait-free access phase; read data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= gpio_pkg::RST_ZERO;
        end else begin
            pready_r <= setup_w;
            pslverr_r <= setup_w & ~hit_w;
            if (setup_w) begin
                prdata_r <= pwrite ? gpio_pkg::RST_ZERO : rd_w;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_r <= gpio_pkg::RST_PINS;
            pin_oe_r <= gpio_pkg::RST_PINS;
            alt0_sel_r <= gpio_pkg::RST_PINS;
            alt1_sel_r <= gpio_pkg::RST_PINS;
            alt2_sel_r <= gpio_pkg::RST_PINS;
            irq_r <= 1'b0;
            capture_r <= 1'b0;
        end else begin
            pin_out_r <= out_w;
            pin_oe_r <= oe_w;
            alt0_sel_r <= alt0_w;
            alt1_sel_r <= alt1_w;
            alt2_sel_r <= alt2_w;
            irq_r <= |masked_w;
            capture_r <= capture_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pin_level = sync2_r;
    assign alt_function_zero_sel = alt0_sel_r;
    assign alt_function_one_sel = alt1_sel_r;
    assign alt_function_two_sel = alt2_sel_r;
    assign timer_capture = capture_r;
    assign irq = irq_r;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    irq_mask_gate_a: assert property (
        ##1 (irq == $past(|(raw_r & mask_r))))
        else $error("irq does not follow masked status");

    raw_clear_a: assert property (
        (wr_w && hit_clear) |=>
            ((raw_r & $past(clr_mask_w & ~evt_w)) == '0))
        else $error("clear did not clear raw status");

    raw_set_a: assert property (
        (|evt_w) |=> ((raw_r & $past(evt_w)) == $past(evt_w)))
        else $error("event did not set raw status");

    raw_sticky_a: assert property (
        !(wr_w && hit_clear) |=>
            ((raw_r & $past(raw_r)) == $past(raw_r)))
        else $error("raw status lost without clear");

    masked_read_a: assert property (
        (setup_w && hit_masked && !pwrite) |=>
            (prdata == {{PAD{1'b0}}, $past(raw_r & mask_r)}))
        else $error("masked status read wrong");

    out_set_a: assert property (
        (wr_w && hit_set) |=>
            ((data_r & $past(wpins_w)) == $past(wpins_w))
            && ((data_r & ~$past(wpins_w)) == $past(data_r & ~wpins_w)))
        else $error("output set word misbehaved");

    out_clr_a: assert property (
        (wr_w && hit_clr) |=> ((data_r & $past(wpins_w)) == '0)
            && ((data_r & ~$past(wpins_w)) == $past(data_r & ~wpins_w)))
        else $error("output clear word misbehaved");

    gpio_drive_a: assert property (
        ##1 ((pin_oe & $past(gpio_w)) == $past(gpio_w & dir_r)))
        else $error("gpio pin drive not gated by direction");

    both_edge_a: assert property (
        ((~sense_r & both_r & (sync2_r ^ prev_r) & ~evt_w) == '0))
        else $error("both-edge change missed");

    level_pol_a: assert property (
        ((sense_r & ~(sync2_r ^ pol_r) & ~evt_w) == '0))
        else $error("level event missed");

    reserved_gpio_a: assert property (
        (func0_r[2:0] inside {3'b010, 3'b011, 3'b110, 3'b111})
            |-> gpio_w[0])
        else $error("reserved code not general purpose");

    capture_route_a: assert property (
        ##1 (timer_capture == $past(capture_nxt)) and
        ((capture_sel_r == '0) |=> (timer_capture == $past(sync2_r[0]))))
        else $error("capture input not routed");

    // bus protocol, event detection, interrupt mask and clear, capture range and per-pin role checks
    one_edge_a: assert property (
        ((~sense_r & ~both_r & ~(pol_r ^ prev_r) & (sync2_r ^ prev_r)
            & evt_w) == '0))
        else $error("opposite edge raised an event");

    mask_block_a: assert property (
        (mask_r == '0) |=> !irq)
        else $error("irq raised with all pins masked");

    raw_read_a: assert property (
        (setup_w && hit_raw && !pwrite) |=>
            (prdata == {{PAD{1'b0}}, $past(raw_r)}))
        else $error("raw status read wrong");

    masked_clear_a: assert property (
        (wr_w && hit_clear) |=>
            ((masked_w & $past(clr_mask_w & ~evt_w)) == '0))
        else $error("clear did not reach masked status");

    alt_zero_sel_a: assert property (
        (func0_r[2:0] == gpio_pkg::FN_ALT_ZERO) |=>
            alt_function_zero_sel[0])
        else $error("pin 0 not in alternate function zero");

    alt_one_sel_a: assert property (
        (func0_r[2:0] == gpio_pkg::FN_ALT_ONE) |=>
            alt_function_one_sel[0])
        else $error("pin 0 not in alternate function one");

    alt_two_sel_a: assert property (
        (func0_r[2:0] == gpio_pkg::FN_ALT_TWO) |=>
            alt_function_two_sel[0])
        else $error("pin 0 not in alternate function two");

    capture_range_a: assert property (
        (capture_sel_r >= SEL_W'(NPINS)) |=> !timer_capture)
        else $error("capture routed from a missing pin");

    gpio_out_a: assert property (
        ##1 ((pin_out & $past(gpio_w)) == $past(gpio_w & data_r)))
        else $error("gpio pin value not taken from data");

    data_read_a: assert property (
        (setup_w && hit_data && !pwrite) |=>
            (prdata == {{PAD{1'b0}}, $past(sync2_r)}))
        else $error("data read does not show pin levels");

    edge_quiet_a: assert property (
        ((~sense_r & ~(sync2_r ^ prev_r) & evt_w) == '0))
        else $error("edge mode raised event on steady pin");

    bus_error_a: assert property (
        (setup_w && !hit_w) |=> (pready && pslverr))
        else $error("unmapped address not refused");

    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    irq_rise_c: cover property ($rose(irq));
    both_edge_c: cover property (|(both_r & (sync2_r ^ prev_r)));
    unmapped_c: cover property (pready && pslverr);
    alt_drive_c: cover property (|(alt_function_zero_sel & pin_oe));
    level_evt_c: cover property (|(sense_r & evt_w));

endmodule

/* File: tb/pin_world.sv */
`timescale 1ns/100ps
// pads plus the three serial peripherals behind the port
module pin_world (
    input wire logic [25:0] pin_out,
    input wire logic [25:0] pin_oe,
    input wire logic [25:0] ext_val,
    output logic [25:0] pin_in,
    output logic [25:0] zero_out,
    output logic [25:0] zero_oe,
    output logic [25:0] one_out,
    output logic [25:0] one_oe,
    output logic [25:0] two_out,
    output logic [25:0] two_oe
);
    // port driver wins; outside world otherwise, zero stands for pull-down
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
    assign zero_out = 26'h3FFFFFF;
    assign zero_oe = 26'h3FFFFFF;
    assign one_out = 26'h0000000;
    assign one_oe = 26'h3FFFFFF;
    assign two_out = 26'h3FFFFFF;
    assign two_oe = 26'h0000000;
endmodule

/* File: tb/gpio_irq_pin_function_tb.sv */
`timescale 1ns/100ps
module gpio_irq_pin_function_tb;
    typedef struct {logic [31:0] data; logic err; logic rd;} note_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, r1, r2;
    logic pready, pslverr, timer_capture, irq;
    logic [25:0] pin_in, pin_out, pin_oe, pin_level;
    logic [25:0] ext_val = 26'h0000000;
    logic [25:0] z_out, z_oe, o_out, o_oe, t_out, t_oe, z_sel, o_sel, t_sel;
    logic [7:0] offs [13] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
        8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44};
    logic [2:0] codes [4] = '{3'h4, 3'h1, 3'h5, 3'h2};
    logic [3:0] fexp [4] = '{4'h9, 4'h5, 4'h2, 4'h0};
    note_s notes[$];
    note_s nt;
    int error_cnt = 0;
    int n_tests = 0;

    always #5 pclk = ~pclk;

    gpio_irq_pin_function dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin_level), .alt_function_zero_out(z_out),
        .alt_function_zero_oe(z_oe), .alt_function_one_out(o_out),
        .alt_function_one_oe(o_oe), .alt_function_two_out(t_out),
        .alt_function_two_oe(t_oe), .alt_function_zero_sel(z_sel),
        .alt_function_one_sel(o_sel), .alt_function_two_sel(t_sel),
        .timer_capture(timer_capture), .irq(irq));

    pin_world world (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .pin_in(pin_in), .zero_out(z_out), .zero_oe(z_oe), .one_out(o_out),
        .one_oe(o_oe), .two_out(t_out), .two_oe(t_oe));

    task automatic check_word(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        #1;
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr_i, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] exp, input logic err);
        notes.push_back('{exp, err, !wr_i});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_i;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h00000000, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000, exp, 1'b0);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // pin 3 only; clear once idle, then apply the trigger step
    task automatic irq_case(input logic s, b, p, v0, v1, e);
        @(posedge pclk);
        ext_val[3] <= v0;
        wr(gpio_pkg::OFF_SENSE, {28'h0000000, s, 3'h0});
        wr(gpio_pkg::OFF_BOTH, {28'h0000000, b, 3'h0});
        wr(gpio_pkg::OFF_POLARITY, {28'h0000000, p, 3'h0});
        wait_cyc(6);
        wr(gpio_pkg::OFF_CLEAR, 32'h00000008);
        @(posedge pclk);
        ext_val[3] <= v1;
        wait_cyc(6);
        rd(gpio_pkg::OFF_RAW, {28'h0000000, e, 3'h0});
        rd(gpio_pkg::OFF_MASKED, {28'h0000000, e, 3'h0});
        check_bit("irq", e, irq);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                check_bit("unrequested answer", 1'b0, 1'b1);
            end else begin
                nt = notes.pop_front();
                check_word("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
                if (nt.rd) begin
                    check_word("prdata", nt.data, prdata);
                end
            end
        end
    end

    initial begin
        #200000;
        error_cnt++;
        $display("unexpected run length: expected end seen timeout");
        wrap_up();
    end

    initial begin
        void'($urandom(32'h4D9B));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            rd(offs[i], offs[i] == gpio_pkg::OFF_FUNC1 ?
                gpio_pkg::RST_FUNC1 : gpio_pkg::RST_ZERO);
        end
        check_word("serial one pins", 32'h3, {30'h0, o_sel[10:9]});
        apb(1'b0, 8'h48, 32'h00000000, 32'h00000000, 1'b1);
        r1 = $urandom;
        wr(gpio_pkg::OFF_BOTH, r1);
        rd(gpio_pkg::OFF_BOTH, r1 & 32'h03FFFFFF);
        $display("test registers done");
        wr(gpio_pkg::OFF_MASK, 32'h00000008);
        irq_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        irq_case(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        irq_case(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        irq_case(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        irq_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        irq_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        wr(gpio_pkg::OFF_SENSE, 32'h00000000);
        wr(gpio_pkg::OFF_MASK, 32'h00000000);
        rd(gpio_pkg::OFF_MASKED, 32'h00000000);
        check_bit("irq masked", 1'b0, irq);
        rd(gpio_pkg::OFF_RAW, 32'h00000008);
        wr(gpio_pkg::OFF_MASK, 32'h00000008);
        wr(gpio_pkg::OFF_CLEAR, 32'h00000000);
        rd(gpio_pkg::OFF_MASKED, 32'h00000008);
        wr(gpio_pkg::OFF_CLEAR, 32'h00000008);
        rd(gpio_pkg::OFF_MASKED, 32'h00000000);
        rd(gpio_pkg::OFF_RAW, 32'h00000000);
        check_bit("irq cleared", 1'b0, irq);
        $display("test interrupts done");
        for (int i = 0; i < 4; i++) begin
            wr(gpio_pkg::OFF_FUNC0, {29'h0, codes[i]});
            wait_cyc(2);
            check_word("pin 0 role", {28'h0, fexp[i]},
                {28'h0, z_sel[0], o_sel[0], t_sel[0], pin_oe[0]});
        end
        wr(gpio_pkg::OFF_FUNC1, 32'h00000000);
        $display("test functions done");
        wr(gpio_pkg::OFF_CAPTURE, 32'h00000005);
        @(posedge pclk);
        ext_val[5] <= 1'b1;
        wait_cyc(5);
        check_bit("capture pin 5", 1'b1, timer_capture);
        wr(gpio_pkg::OFF_CAPTURE, 32'h0000001A);
        wait_cyc(3);
        check_bit("capture no pin", 1'b0, timer_capture);
        wr(gpio_pkg::OFF_CAPTURE, 32'h00000006);
        wait_cyc(3);
        check_bit("capture pin 6", 1'b0, timer_capture);
        $display("test capture done");
        r1 = $urandom & 32'h03FFFFFF;
        r2 = $urandom;
        wr(gpio_pkg::OFF_DATA, 32'h00000000);
        wr(gpio_pkg::OFF_OUT_SET, r1);
        wr(gpio_pkg::OFF_OUT_CLR, r2);
        check_word("pin_oe", 32'h00000000, {6'h00, pin_oe});
        wr(gpio_pkg::OFF_DIRECTION, 32'h03FFFFFF);
        wait_cyc(4);
        rd(gpio_pkg::OFF_DATA, r1 & ~r2 & 32'h03FFFFFF);
        r2 = r1 & ~r2 & 32'h03FFFFFF;
        check_word("pin_out", r2, {6'h00, pin_out});
        check_word("pin_level", r2, {6'h00, pin_level});
        $display("test output bits done");
        wrap_up();
    end
endmodule
